//--- include/clkgen_pkg.sv
// Constants shared by the base clock selector design
package clkgen_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL = 6'h1c; // pll_control_reg
   localparam logic [5:0] IDX_BW = 6'h1d; // pll_bandwidth_reg
   localparam logic [5:0] IDX_PROG = 6'h1e; // pll_programming

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_IE_BIT = 7; // lock_irq_enable
   localparam int CTRL_FLAG_BIT = 6; // lock_change_flag
   localparam int CTRL_ON_BIT = 5; // pll_power_on
   localparam int CTRL_BCS_BIT = 4; // base_clock_select
   localparam logic [3:0] CTRL_UNUSED_VAL = 4'hf; // Unused bits read as ones

   // ------------------------------------------------------------
   // Bandwidth register fields
   // ------------------------------------------------------------
   localparam int BW_AUTO_BIT = 7; // Automatic bandwidth mode
   localparam int BW_LOCK_BIT = 6; // Lock indicator
   localparam int BW_ACQ_BIT = 5; // Tracking (1) or acquisition (0)

   // ------------------------------------------------------------
   // Programming register fields and reset values
   // ------------------------------------------------------------
   localparam int PROG_MUL_LSB = 4; // multiplier_field in bits 7:4
   localparam int PROG_RANGE_LSB = 0; // range_field in bits 3:0
   localparam logic [3:0] MUL_RESET = 4'h6;
   localparam logic [3:0] RANGE_RESET = 4'h6;
   localparam logic [3:0] MUL_ZERO = 4'h0;
   localparam logic [3:0] MUL_ONE = 4'h1;
   localparam logic [3:0] RANGE_OFF = 4'h0;
   localparam logic ON_RESET = 1'b1; // PLL on out of reset

   // ------------------------------------------------------------
   // Transition controller timing, in source clock cycles
   // ------------------------------------------------------------
   localparam logic [1:0] SWITCH_CYCLES = 2'h3;

   // Transition controller states
   typedef enum logic [1:0] {
      SW_RUN,
      SW_STOP_OLD,
      SW_START_NEW
   } switch_state_e;
endpackage : clkgen_pkg

//--- logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pin in, filtered level out
   input wire logic i_pin,
   output logic o_level
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic s1; // First stage, read only by s2
      logic s2;
      logic s3;
      logic lvl; // Accepted level
   } sync_s;

   sync_s st_reg;
   sync_s st_next;

   // Accept a change only once the second and third stage agree
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = i_pin;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3)
      begin
         st_next.lvl = st_reg.s3;
      end
   end

   // Register the state
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_level = st_reg.lvl;
endmodule : pin_sync
`default_nettype wire

//--- logic/pll_base_clock_selector.sv
// Base clock selector: registers, interlocks, glitch-free switch, dividers
// Operation
// [RULE1] Multiplier zero acts as multiplier one
// [RULE2] Range zero disables PLL, forces crystal
// [RULE3] Switch waits three cycles of each clock
// [RULE4] Base clock static during source transition
// [RULE5] Switch output divided by two
// [RULE6] Bus clock is half base clock
// [RULE7] One select bit picks crystal or VCO
// [RULE8] Select cannot be set while PLL off
// [RULE9] PLL cannot turn off while VCO selected
// [RULE10] Interlocks judged against state before write
// [RULE11] Software writes multiplier in upper nibble
// [RULE12] Software writes range in lower nibble
// [RULE13] Software rounds VCO over crystal ratio
// [RULE14] Software rounds VCO over 4.9152 MHz
// [RULE15] Oscillator enable gates crystal and PLL
// [RULE16] Lock detector drives interrupt request output
// [RULE17] Select one is VCO, zero crystal
// [RULE18] Reset and stop clear the select bit
// [RULE19] Software enables PLL before selecting VCO
// [RULE20] Stop old clock low, then start new
`timescale 1ns/1ps
`default_nettype none
module pll_base_clock_selector
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Source clocks and lock detector, all from pins
   input wire logic i_crystal_clock,
   input wire logic i_vco_clock,
   input wire logic i_pll_locked,
   // System integration controls
   input wire logic i_osc_enable_in,
   input wire logic i_stop,
   // Analog control outputs
   output logic o_osc_run,
   output logic o_pll_run,
   output logic o_tracking,
   output logic [3:0] o_feedback_div,
   output logic [3:0] o_range_field,
   // Clock outputs and interrupt
   output logic o_base_clock_out,
   output logic o_bus_clock,
   output logic o_clockgen_irq
);
   // ------------------------------------------------------------
   // Local functions
   // ------------------------------------------------------------

   // Feedback divider value for a multiplier field
   function automatic logic [3:0] eff_mul(input logic [3:0] f);
      eff_mul = (f == clkgen_pkg::MUL_ZERO) ? clkgen_pkg::MUL_ONE : f; // see [RULE1]
   endfunction : eff_mul

   // PLL may run only when enabled, range valid and oscillator allowed
   function automatic logic pll_allowed(input logic on, input logic [3:0] rng,
                                        input logic osc);
      pll_allowed = on && (rng != clkgen_pkg::RANGE_OFF) && osc; // see [RULE2] [RULE15]
   endfunction : pll_allowed

   // ------------------------------------------------------------
   // Synchronised pins
   // ------------------------------------------------------------
   logic xtal_lvl; // Crystal clock level
   logic vco_lvl; // VCO clock level
   logic lock_lvl; // Lock detector level

   pin_sync u_sync_xtal
   (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_crystal_clock),
      .o_level(xtal_lvl)
   );

   pin_sync u_sync_vco
   (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_vco_clock),
      .o_level(vco_lvl)
   );

   pin_sync u_sync_lock
   (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_pll_locked),
      .o_level(lock_lvl)
   );

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      // Registers
      logic ie; // lock_irq_enable
      logic flag; // lock_change_flag
      logic pll_on; // pll_power_on
      logic base_clock_select; // base_clock_select
      logic autobw; // Automatic bandwidth mode
      logic acq; // Tracking mode bit
      logic [3:0] mul; // multiplier_field
      logic [3:0] rng; // range_field
      // Bus
      logic ack;
      logic [7:0] rdat;
      // Pin history for edge detection
      logic xtal_prev;
      logic vco_prev;
      logic lock_prev;
      // Transition controller
      clkgen_pkg::switch_state_e sw;
      logic src_vco; // Source now driving the switch
      logic [1:0] cnt; // Source cycles counted during switch
      // Outputs
      logic base;
      logic bus;
      logic osc_run;
      logic pll_run;
      logic irq;
      logic [3:0] fdiv; // Feedback divider handed to the loop
   } sel_s;

   sel_s st_reg;
   sel_s st_next;

   // ------------------------------------------------------------
   // Combinational helpers
   // ------------------------------------------------------------
   logic bus_req; // Fresh request seen this cycle
   logic wr_en; // Write with low byte lane enabled
   logic [5:0] idx; // Register index
   logic [7:0] wb; // Write byte
   logic xtal_rise;
   logic vco_rise;
   logic old_rise; // Rising edge of the source being left
   logic old_lvl;
   logic new_rise; // Rising edge of the source being taken
   logic new_lvl;
   logic src_rise; // Rising edge of the active source
   logic want_vco; // Selection requested by the register

   always_comb
   begin
      bus_req = i_wb_cyc && i_wb_stb && !st_reg.ack;
      wr_en = bus_req && i_wb_we && i_wb_sel[0];
      idx = i_wb_adr[7:2];
      wb = i_wb_dat[7:0];
      xtal_rise = xtal_lvl && !st_reg.xtal_prev;
      vco_rise = vco_lvl && !st_reg.vco_prev;
      want_vco = st_reg.base_clock_select; // see [RULE7] [RULE17]
      old_rise = st_reg.src_vco ? vco_rise : xtal_rise;
      old_lvl = st_reg.src_vco ? vco_lvl : xtal_lvl;
      new_rise = st_reg.src_vco ? xtal_rise : vco_rise;
      new_lvl = st_reg.src_vco ? xtal_lvl : vco_lvl;
      src_rise = old_rise;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.xtal_prev = xtal_lvl;
      st_next.vco_prev = vco_lvl;
      st_next.lock_prev = lock_lvl;

      // Wishbone: answer one cycle after the request, drop after one
      st_next.ack = bus_req;
      if (bus_req)
      begin
         case (idx)
            clkgen_pkg::IDX_CTRL:
            begin
               st_next.rdat = {st_reg.ie && st_reg.autobw, st_reg.flag && st_reg.autobw,
                               st_reg.pll_on, st_reg.base_clock_select, clkgen_pkg::CTRL_UNUSED_VAL};
            end
            clkgen_pkg::IDX_BW:
            begin
               st_next.rdat = {st_reg.autobw, lock_lvl && st_reg.autobw, st_reg.acq, 5'h00};
            end
            clkgen_pkg::IDX_PROG:
            begin
               st_next.rdat = {st_reg.mul, st_reg.rng};
            end
            default:
            begin
               // Unmapped addresses answer with zero
               st_next.rdat = 8'h00;
            end
         endcase
      end

      // Control register write, interlocks use the old state
      if (wr_en && idx == clkgen_pkg::IDX_CTRL)
      begin
         if (st_reg.autobw)
         begin
            // Enable is writable only in automatic mode
            st_next.ie = wb[clkgen_pkg::CTRL_IE_BIT];
         end
         // Clearing is refused while the VCO is selected
         if (wb[clkgen_pkg::CTRL_ON_BIT] || !st_reg.base_clock_select) // see [RULE9] [RULE10]
         begin
            st_next.pll_on = wb[clkgen_pkg::CTRL_ON_BIT];
         end
         // Setting is refused while the PLL is off or range is zero
         if (!wb[clkgen_pkg::CTRL_BCS_BIT] ||
             (st_reg.pll_on && st_reg.rng != clkgen_pkg::RANGE_OFF)) // see [RULE8] [RULE10]
         begin
            st_next.base_clock_select = wb[clkgen_pkg::CTRL_BCS_BIT]; // see [RULE2]
         end
      end

      // Bandwidth register write
      if (wr_en && idx == clkgen_pkg::IDX_BW)
      begin
         st_next.autobw = wb[clkgen_pkg::BW_AUTO_BIT];
         st_next.acq = wb[clkgen_pkg::BW_ACQ_BIT];
      end

      // Programming register write, locked while the PLL is on
      if (wr_en && idx == clkgen_pkg::IDX_PROG && !st_reg.pll_on)
      begin
         st_next.mul = wb[clkgen_pkg::PROG_MUL_LSB +: 4];
         st_next.rng = wb[clkgen_pkg::PROG_RANGE_LSB +: 4];
      end

      // Zero range forces the crystal source
      if (st_reg.rng == clkgen_pkg::RANGE_OFF)
      begin
         st_next.base_clock_select = 1'b0; // see [RULE2]
      end

      // Stop returns the selection to the crystal
      if (i_stop)
      begin
         st_next.base_clock_select = 1'b0; // see [RULE18]
      end

      // Lock change flag: a lock toggle beats a clearing read
      if (bus_req && !i_wb_we && idx == clkgen_pkg::IDX_CTRL)
      begin
         st_next.flag = 1'b0;
      end
      if (st_reg.autobw && (lock_lvl != st_reg.lock_prev))
      begin
         st_next.flag = 1'b1;
      end
      st_next.irq = st_next.flag && st_next.ie && st_next.autobw; // see [RULE16]

      // Analog enables
      st_next.osc_run = i_osc_enable_in; // see [RULE15]
      st_next.pll_run = pll_allowed(st_next.pll_on, st_next.rng, i_osc_enable_in);
      st_next.fdiv = eff_mul(st_next.mul); // see [RULE1]

      // Transition controller; base clock only moves in SW_RUN
      case (st_reg.sw)
         clkgen_pkg::SW_RUN:
         begin
            if (src_rise)
            begin
               st_next.base = !st_reg.base; // see [RULE5]
               if (!st_reg.base)
               begin
                  st_next.bus = !st_reg.bus; // see [RULE6]
               end
            end
            if (want_vco != st_reg.src_vco)
            begin
               st_next.sw = clkgen_pkg::SW_STOP_OLD;
               st_next.cnt = 2'h0;
            end
         end
         clkgen_pkg::SW_STOP_OLD:
         begin
            // Old source is cut on its low phase after its cycles
            if (old_rise && st_reg.cnt != clkgen_pkg::SWITCH_CYCLES)
            begin
               st_next.cnt = st_reg.cnt + 2'h1; // see [RULE3]
            end
            if ((st_reg.cnt == clkgen_pkg::SWITCH_CYCLES) && !old_lvl) // see [RULE20]
            begin
               st_next.sw = clkgen_pkg::SW_START_NEW;
               st_next.cnt = 2'h0;
            end
         end
         clkgen_pkg::SW_START_NEW:
         begin
            // Base clock stays frozen until the new source is taken
            if (new_rise && st_reg.cnt != clkgen_pkg::SWITCH_CYCLES)
            begin
               st_next.cnt = st_reg.cnt + 2'h1; // see [RULE3] [RULE4]
            end
            if ((st_reg.cnt == clkgen_pkg::SWITCH_CYCLES) && !new_lvl) // see [RULE20]
            begin
               st_next.src_vco = !st_reg.src_vco;
               st_next.sw = clkgen_pkg::SW_RUN;
               st_next.cnt = 2'h0;
            end
            // Request withdrawn in any cycle but the completing one: the new source may be stopped, keep the old one
            if (want_vco == st_reg.src_vco)
            begin
               st_next.sw = clkgen_pkg::SW_RUN;
               st_next.cnt = 2'h0;
            end
         end
         default:
         begin
            st_next.sw = clkgen_pkg::SW_RUN;
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         st_reg <= '0;
         st_reg.pll_on <= clkgen_pkg::ON_RESET;
         st_reg.base_clock_select <= 1'b0; // see [RULE18]
         st_reg.mul <= clkgen_pkg::MUL_RESET;
         // Reset multiplier is nonzero, so the divider shows it as is
         st_reg.fdiv <= clkgen_pkg::MUL_RESET;
         st_reg.rng <= clkgen_pkg::RANGE_RESET;
         st_reg.sw <= clkgen_pkg::SW_RUN;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from the state register
   // ------------------------------------------------------------
   assign o_wb_ack = st_reg.ack;
   assign o_wb_dat = {24'h000000, st_reg.rdat};
   assign o_osc_run = st_reg.osc_run;
   assign o_pll_run = st_reg.pll_run;
   assign o_tracking = st_reg.acq;
   assign o_feedback_div = st_reg.fdiv; // see [RULE1]
   assign o_range_field = st_reg.rng;
   assign o_base_clock_out = st_reg.base;
   assign o_bus_clock = st_reg.bus;
   assign o_clockgen_irq = st_reg.irq;
endmodule : pll_base_clock_selector
`default_nettype wire

//--- sim/clkgen_props.sv
// Port-level checks on the base clock selector
`timescale 1ns/1ps
`default_nettype none
module clkgen_props
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   // Controls and outputs
   input wire logic i_osc_enable_in,
   input wire logic o_osc_run,
   input wire logic o_pll_run,
   input wire logic [3:0] o_feedback_div,
   input wire logic [3:0] o_range_field,
   input wire logic o_base_clock_out,
   input wire logic o_bus_clock
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ----
   // Bus sequences
   // ----
   // Request taken only on an idle answer line
   sequence take_s;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence rd_ctrl_s;
      take_s ##0 (!i_wb_we && i_wb_adr == 8'h70);
   endsequence
   sequence rd_prog_s;
      take_s ##0 (!i_wb_we && i_wb_adr == 8'h78);
   endsequence
   // ----
   // Properties
   // ----
   ack_next_a: assert property (take_s |=> o_wb_ack)
      else $error("ack missing after request");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   ctrl_fill_a: assert property (rd_ctrl_s |=> o_wb_dat[3:0] == 4'hf)
      else $error("control low bits not ones");
   prog_range_a: assert property (rd_prog_s |=> o_wb_dat[3:0] == o_range_field)
      else $error("range output differs from register");
   mul_one_a: assert property (rd_prog_s |=> o_feedback_div ==
      ((o_wb_dat[7:4] == 4'h0) ? 4'h1 : o_wb_dat[7:4]))
      else $error("feedback divider wrong");
   range_off_a: assert property ((o_range_field == 4'h0) [*2] |-> !o_pll_run)
      else $error("loop runs with zero range");
   osc_gate_a: assert property ((!i_osc_enable_in) [*2] |-> !o_osc_run && !o_pll_run)
      else $error("oscillator or loop runs while disabled");
   // Source is no faster than a tenth of the system clock, so no runts
   base_width_a: assert property ($changed(o_base_clock_out) |=>
      $stable(o_base_clock_out) [*8])
      else $error("base clock pulse too short");
   bus_follow_a: assert property ($rose(o_base_clock_out) |-> ##[0:1]
      $changed(o_bus_clock))
      else $error("bus clock missed a base edge");
endmodule : clkgen_props
bind pll_base_clock_selector clkgen_props clkgen_props_inst (.i_clk, .i_rst_n, .i_wb_cyc,
   .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_osc_enable_in, .o_osc_run,
   .o_pll_run, .o_feedback_div, .o_range_field, .o_base_clock_out, .o_bus_clock);
`default_nettype wire

//--- sim/src_model.sv
// Crystal, VCO and lock detector stand-in
`timescale 1ns/1ps
`default_nettype none
module src_model
#(
   parameter int XTAL_HALF_NS = 35,
   parameter int VCO_HALF_NS = 25,
   parameter int LOCK_CYCLES = 40
)
(
   // System clock
   input wire logic i_clk,
   // Run enables from the selector
   input wire logic i_osc_run,
   input wire logic i_pll_run,
   // Source clocks and lock level
   output logic o_crystal_clock,
   output logic o_vco_clock,
   output logic o_pll_locked
);
   int lock_cnt = 0; // Cycles since loop start
   // Crystal rests low when disabled; offset keeps edges off i_clk
   initial
   begin
      o_crystal_clock = 1'b0;
      #1;
      forever
      begin
         #(XTAL_HALF_NS);
         o_crystal_clock = i_osc_run ? ~o_crystal_clock : 1'b0;
      end
   end
   // VCO rests low while the loop is off
   initial
   begin
      o_vco_clock = 1'b0;
      #1;
      forever
      begin
         #(VCO_HALF_NS);
         o_vco_clock = i_pll_run ? ~o_vco_clock : 1'b0;
      end
   end
   // Lock settles a while after start, drops when stopped
   initial o_pll_locked = 1'b0;
   always @(posedge i_clk)
   begin
      if (!i_pll_run)
      begin
         lock_cnt <= 0;
         o_pll_locked <= 1'b0;
      end
      else if (lock_cnt == LOCK_CYCLES)
         o_pll_locked <= 1'b1;
      else
         lock_cnt <= lock_cnt + 1;
   end
endmodule : src_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the base clock selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----
   // Stimulus and observed signals
   // ----
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic osc_en = 1'b1;
   logic stop = 1'b0;
   logic [31:0] rdat;
   logic ack, xclk, vclk, locked, osc_run, pll_run, base, bus, irq, trk;
   logic [3:0] fdiv, rng;
   logic [7:0] q, v;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 58;
   int n;
   // Interlock table: written value, expected readback
   logic [7:0] lk_w [5] = '{8'h30, 8'h00, 8'h00, 8'h10, 8'h30};
   logic [7:0] lk_r [5] = '{8'h3f, 8'h2f, 8'h0f, 8'h0f, 8'h2f};
   always #2.5 i_clk = ~i_clk;
   pll_base_clock_selector pll_base_clock_selector_inst (.i_clk, .i_rst_n, .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_crystal_clock(xclk), .i_vco_clock(vclk),
      .i_pll_locked(locked), .i_osc_enable_in(osc_en), .i_stop(stop), .o_osc_run(osc_run),
      .o_pll_run(pll_run), .o_tracking(trk), .o_feedback_div(fdiv), .o_range_field(rng),
      .o_base_clock_out(base), .o_bus_clock(bus), .o_clockgen_irq(irq));
   src_model src_model_inst (.i_clk, .i_osc_run(osc_run), .i_pll_run(pll_run),
      .o_crystal_clock(xclk), .o_vco_clock(vclk), .o_pll_locked(locked));
   // ----
   // Helpers
   // ----
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic fail(input string msg);
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, msg);
   endtask : fail
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
   endtask : check_byte
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("bit %b, expected %b", got, exp));
   endtask : check_bit
   task automatic check_count(input int got, input int exp);
      samples_checked++;
      if (got != exp) fail($sformatf("period %0d, expected %0d", got, exp));
   endtask : check_count
   // Expected feedback divider: zero behaves as one
   function automatic logic [3:0] mul_of(input logic [3:0] m);
      return (m == 4'h0) ? 4'h1 : m;
   endfunction : mul_of
   // Programming byte from target VCO and crystal rates, both ratios rounded
   function automatic logic [7:0] prog_of(input real vco_mhz, input real xtal_mhz);
      return {4'($rtoi(vco_mhz / xtal_mhz + 0.5)), 4'($rtoi(vco_mhz / 4.9152 + 0.5))};
   endfunction : prog_of
   // One classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      sel <= 4'h1;
      do
      begin
         @(posedge i_clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         fail("no bus answer");
         wrap_up();
      end
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      check_byte(q, exp);
   endtask : rd
   // Cycles between the third and fourth rising edge of base or bus clock
   task automatic period(input logic use_bus, input int exp);
      int k, t, e;
      logic p, c;
      k = 0;
      t = 0;
      e = 0;
      p = use_bus ? bus : base;
      while (e < 4 && k < 900)
      begin
         @(posedge i_clk);
         k++;
         t++;
         c = use_bus ? bus : base;
         if (c && !p) e++;
         if (c && !p && e == 3) t = 0;
         p = c;
      end
      if (e < 4)
      begin
         fail("clock stalled");
         wrap_up();
      end
      check_count(t, exp);
   endtask : period
   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test
   // ----
   // Main sequence
   // ----
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(8'h78, 8'h66);
      rd(8'h70, 8'h2f);
      rd(8'h40, 8'h00);
      period(1'b0, 28);
      period(1'b1, 56);
      end_test("reset");
      foreach (lk_w[i])
      begin
         wb(1'b1, 8'h70, lk_w[i]);
         rd(8'h70, lk_r[i]);
      end
      wb(1'b1, 8'h70, 8'h00);
      end_test("interlocks");
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 8'h05 : (i == 1) ? 8'h1c : 8'($random(seed));
         wb(1'b1, 8'h78, v);
         rd(8'h78, v);
         check_byte({4'h0, fdiv}, {4'h0, mul_of(v[7:4])});
         check_byte({4'h0, rng}, {4'h0, v[3:0]});
      end
      wb(1'b1, 8'h78, 8'h80);
      wb(1'b1, 8'h70, 8'h20);
      wb(1'b1, 8'h70, 8'h30);
      rd(8'h70, 8'h2f);
      check_bit(pll_run, 1'b0);
      wb(1'b1, 8'h78, 8'h87);
      rd(8'h78, 8'h80);
      wb(1'b1, 8'h70, 8'h00);
      wb(1'b1, 8'h78, prog_of(32.0, 4.0));
      rd(8'h78, 8'h87);
      end_test("programming");
      wb(1'b1, 8'h74, 8'ha0);
      wb(1'b1, 8'h70, 8'ha0);
      n = 0;
      while (irq !== 1'b1 && n < 300)
      begin
         @(posedge i_clk);
         n++;
      end
      check_bit(irq, 1'b1);
      check_bit(trk, 1'b1); // Tracking pin follows the stored mode bit
      rd(8'h74, 8'he0);
      rd(8'h70, 8'hef);
      repeat (3) @(posedge i_clk);
      check_bit(irq, 1'b0);
      end_test("lock interrupt");
      wb(1'b1, 8'h70, 8'hb0);
      period(1'b0, 20);
      period(1'b1, 40);
      stop <= 1'b1;
      repeat (3) @(posedge i_clk);
      stop <= 1'b0;
      rd(8'h70, 8'haf);
      period(1'b0, 28);
      end_test("source switch");
      osc_en <= 1'b0;
      repeat (4) @(posedge i_clk);
      check_bit(osc_run, 1'b0);
      check_bit(pll_run, 1'b0);
      osc_en <= 1'b1;
      end_test("oscillator gate");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
